// file: include/synth_pkg.sv
// Purpose: Constants and types of the synthesizer programming host.
// Assumes: A 125 MHz system clock.
// Notes: Times are kept in their own unit and turned into cycles here.
package synth_pkg;
	// Clock period in ns and cycles per unit.
	localparam int CLK_PERIOD_NS = 8;
	localparam int CYC_PER_US = 1000 / CLK_PERIOD_NS;
	localparam int CYC_PER_MS = 1000000 / CLK_PERIOD_NS;
	// Waits in milliseconds.
	localparam int FIRST_SETTLE_MS = 40;
	localparam int RESETTLE_MS = 20;
	localparam int LOCK_CHECK_MS = 20;
	localparam int SWITCH_MS = 5;
	localparam int PREAMBLE_MS = 15;
	localparam int COLD_EXTRA_MS = 20;
	localparam int FIRST_SETTLE_CYC = FIRST_SETTLE_MS * CYC_PER_MS;
	localparam int RESETTLE_CYC = RESETTLE_MS * CYC_PER_MS;
	localparam int LOCK_CHECK_CYC = LOCK_CHECK_MS * CYC_PER_MS;
	localparam int SWITCH_CYC = SWITCH_MS * CYC_PER_MS;
	localparam int PREAMBLE_CYC = PREAMBLE_MS * CYC_PER_MS;
	localparam int COLD_EXTRA_CYC = COLD_EXTRA_MS * CYC_PER_MS;
	// Preamble half bit in microseconds.
	localparam int PREAMBLE_HALF_US = 104;
	localparam int PREAMBLE_HALF_CYC = PREAMBLE_HALF_US * CYC_PER_US;
	// A new lock level must hold this long to be believed.
	localparam int LOCK_QUAL_US = 20;
	localparam int LOCK_QUAL_CYC = LOCK_QUAL_US * CYC_PER_US;
	// Serial clock half period in system clocks.
	localparam int SCLK_HALF_CYC = 8;
	// Word layout.
	localparam int WORD_BITS = 19;
	localparam logic [13:0] REF_DIVIDER = 14'h06a4;
	localparam logic [15:0] BASE_DIVISION = 16'h8858;
	localparam logic [6:0] NUM_CHANNELS = 7'h32;
	localparam int PRESCALE_SHIFT = 6;
	localparam logic CHARGE_PUMP_BIT = 1'h0;
	localparam logic LOCK_SEL_BIT = 1'h0;
	localparam logic PHASE_POL_BIT = 1'h1;
	localparam logic SELECT_REF = 1'h1;
	localparam logic SELECT_DIV = 1'h0;
	// Software port offsets.
	localparam logic [3:0] CTRL_OFS = 4'h0;
	localparam logic [3:0] CHAN_OFS = 4'h4;
	localparam logic [3:0] STATUS_OFS = 4'h8;
	// Control fields.
	localparam int CTRL_POWER = 0;
	localparam int CTRL_TX = 1;
	localparam int CTRL_COLD = 2;
	// Status fields.
	localparam int ST_POWERED = 0;
	localparam int ST_READY = 1;
	localparam int ST_LOCKED = 2;
	localparam int ST_BUSY = 3;
	localparam int ST_LOCK_FAIL = 4;
	localparam int ST_REFUSED = 5;
	localparam int ST_TX_MODE = 6;
	localparam int ST_PREAMBLE = 7;
	// Values after reset.
	localparam logic [2:0] CTRL_RESET = 3'h0;
	localparam logic [6:0] CHAN_RESET = 7'h00;
	// Sequencer states.
	typedef enum logic [3:0] {
		SQ_OFF, SQ_UNPROG, SQ_SEND_REF, SQ_WAIT_REF, SQ_SEND_DIV, SQ_WAIT_DIV,
		SQ_SETTLE, SQ_RX, SQ_RX_WAIT, SQ_TX_WAIT, SQ_PREAMBLE, SQ_TX
	} seq_state_t;
	// Serial shifter states.
	typedef enum logic [1:0] {SH_IDLE, SH_LOW, SH_HIGH, SH_LATCH} shift_state_t;
endpackage : synth_pkg

// file: include/shift_if.sv
// Purpose: Carries one programming word from the sequencer to the shifter.
// Assumes: Both ends run on sys_clk.
// Notes: start is taken only while busy is low.
`timescale 1ns/100ps
interface shift_if;
	logic start; // Request to send word.
	logic [18:0] word; // Sent most significant bit first.
	logic busy; // Shifter is sending.
	logic done; // One-cycle pulse in the same cycle the latch strobe falls.
	modport ctrl (output start, output word, input busy, input done);
	modport shifter (input start, input word, output busy, output done);
endinterface : shift_if

// file: hw/serial_shifter.sv
// Purpose: Shifts out one 19-bit word, then strobes the latch.
// Assumes: The word need only be valid in the cycle start is taken; it is copied then.
// Notes: Data changes while the serial clock is low, so the device sees it stable.
`timescale 1ns/100ps
module serial_shifter (
	input wire logic sys_clk,
	input wire logic rst_n,
	shift_if.shifter sq,
	output logic pll_sclk,
	output logic pll_sdata,
	output logic latch_strobe
);
	synth_pkg::shift_state_t state_ff; // Present phase.
	logic [18:0] sreg_ff; // Bits still to be sent, top bit on the line.
	logic [4:0] bits_ff; // Bits already clocked.
	logic [3:0] half_ff; // Half period divider.
	logic done_ff; // Completion pulse.
	wire tick = (half_ff == 4'(synth_pkg::SCLK_HALF_CYC - 1)); // End of a half period.
	wire take = (state_ff == synth_pkg::SH_IDLE) && sq.start; // Word accepted.
	wire last = (bits_ff == 5'(synth_pkg::WORD_BITS - 1)); // Final bit is out.

	assign sq.busy = (state_ff != synth_pkg::SH_IDLE);
	assign sq.done = done_ff;

	// Divider restarts per word so every half period is full.
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			half_ff <= 4'h0;
		end else if (take || tick || state_ff == synth_pkg::SH_IDLE) begin
			half_ff <= 4'h0;
		end else begin
			half_ff <= half_ff + 4'h1;
		end
	end

	// Low half sets data, the rise clocks it in, then the latch pulse.
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			state_ff <= synth_pkg::SH_IDLE;
			sreg_ff <= 19'h00000;
			bits_ff <= 5'h00;
			pll_sclk <= 1'b0;
			pll_sdata <= 1'b0;
			latch_strobe <= 1'b0;
			done_ff <= 1'b0;
		end else begin
			done_ff <= 1'b0;
			case (state_ff)
				synth_pkg::SH_IDLE: begin
					if (take) begin
						sreg_ff <= sq.word; // (R24)
						pll_sdata <= sq.word[18];
						bits_ff <= 5'h00;
						state_ff <= synth_pkg::SH_LOW;
					end
				end
				synth_pkg::SH_LOW: begin
					if (tick) begin
						pll_sclk <= 1'b1; // (R1)
						state_ff <= synth_pkg::SH_HIGH;
					end
				end
				synth_pkg::SH_HIGH: begin
					if (tick) begin
						pll_sclk <= 1'b0;
						if (last) begin
							latch_strobe <= 1'b1; // (R3)
							state_ff <= synth_pkg::SH_LATCH;
						end else begin
							sreg_ff <= {sreg_ff[17:0], 1'b0};
							pll_sdata <= sreg_ff[17]; // (R24)
							bits_ff <= bits_ff + 5'h01;
							state_ff <= synth_pkg::SH_LOW;
						end
					end
				end
				synth_pkg::SH_LATCH: begin
					if (tick) begin
						latch_strobe <= 1'b0; // (R2)
						done_ff <= 1'b1;
						state_ff <= synth_pkg::SH_IDLE;
					end
				end
				default: begin
					state_ff <= synth_pkg::SH_IDLE;
				end
			endcase
		end
	end
endmodule : serial_shifter

// file: hw/lock_qualifier.sv
// Purpose: Synchronises the lock indicator and filters its early chatter.
// Assumes: The indicator is asynchronous to sys_clk.
// Notes: Both edges must hold for the qualify time, which delays loss of lock too.
`timescale 1ns/100ps
module lock_qualifier (
	input wire logic sys_clk,
	input wire logic rst_n,
	input wire logic lock_raw,
	output logic lock_ok
);
	logic meta_ff; // First synchroniser stage, read only by the second.
	logic sync_ff; // Second synchroniser stage.
	logic [11:0] cnt_ff; // Time the synced level has differed.
	wire differs = (sync_ff != lock_ok); // Candidate new level.
	wire held = (cnt_ff == 12'(synth_pkg::LOCK_QUAL_CYC - 1)); // Held long enough.

	// Two-stage synchroniser.
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			meta_ff <= 1'b0;
			sync_ff <= 1'b0;
		end else begin
			meta_ff <= lock_raw;
			sync_ff <= meta_ff;
		end
	end

	// Any return to the old level restarts the count, so glitches never pass.
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			cnt_ff <= 12'h000;
			lock_ok <= 1'b0;
		end else if (!differs) begin
			cnt_ff <= 12'h000; // (R13)
		end else if (held) begin
			cnt_ff <= 12'h000;
			lock_ok <= sync_ff; // (R22)
		end else begin
			cnt_ff <= cnt_ff + 12'h001;
		end
	end
endmodule : lock_qualifier

// file: hw/synth_host_ctrl.sv
// Purpose: Host controller that powers, programs and switches the radio module.
// Assumes: Software uses the plain register port; pins face the module directly.
// Notes: Long waits are parameters so a simulation can shorten them.
// Operation
// (R1) Device clocks data on serial rising edge.
// (R2) Latch strobe stays low while shifting.
// (R3) Latch strobe rise loads selected latch.
// (R4) Reference and divider words any order.
// (R5) Reference word carries phase polarity one.
// (R6) Ports inactive first, then module power.
// (R7) Wait 40 ms after first programming.
// (R8) Wait 20 ms after later programming.
// (R9) Reprogram channel only in receive mode.
// (R10) Receive switch, same channel: 5 ms.
// (R11) Transmit switch, preset channel: 5 ms.
// (R12) Check lock high 20 ms after change.
// (R13) Qualify lock indicator against glitches.
// (R14) Send alternating preamble 15 ms after transmit.
// (R15) Allow extra 20 ms receive delay cold.
// (R16) Fifty channels, one division step each.
// (R17) Reference counter programmed to 1700.
// (R18) Division ratio is offset VCO over rate.
// (R19) First entry ratio 34904, counters 545/24.
// (R20) Swallow wraps at 63 into next counter.
// (R21) Charge pump and lock output bits zero.
// (R22) Lock indicator high means locked.
// (R23) Selects active low, one at a time.
// (R24) Nineteen bits MSB first, then one strobe.
//
// The placing of the registers and strobed register access are this design's own decisions.
`timescale 1ns/100ps
module synth_host_ctrl #(
	parameter int FIRST_SETTLE_CYC = synth_pkg::FIRST_SETTLE_CYC,
	parameter int RESETTLE_CYC = synth_pkg::RESETTLE_CYC,
	parameter int LOCK_CHECK_CYC = synth_pkg::LOCK_CHECK_CYC,
	parameter int SWITCH_CYC = synth_pkg::SWITCH_CYC,
	parameter int PREAMBLE_CYC = synth_pkg::PREAMBLE_CYC,
	parameter int COLD_EXTRA_CYC = synth_pkg::COLD_EXTRA_CYC,
	parameter int PREAMBLE_HALF_CYC = synth_pkg::PREAMBLE_HALF_CYC
) (
	input wire logic sys_clk,
	input wire logic rstn,
	input wire logic [3:0] addr,
	input wire logic [31:0] wdata,
	input wire logic wr,
	input wire logic rd,
	output logic [31:0] rdata,
	input wire logic tx_bit,
	output logic pll_sclk,
	output logic pll_sdata,
	output logic latch_strobe,
	input wire logic lock_indicator,
	output logic tx_select_n,
	output logic rx_select_n,
	output logic power_en,
	output logic transmit_data_in
);
	logic rst_meta_ff; // Reset release, first stage.
	logic rst_n; // Released reset used by all logic.
	synth_pkg::seq_state_t state_ff; // Sequencer state.
	synth_pkg::seq_state_t nxt_state; // Its next value.
	logic [2:0] ctrl_ff; // Power, transmit and cold requests.
	logic [6:0] chan_ff; // Channel index to program.
	logic pend_ff; // A channel change is waiting.
	logic first_ff; // Next settle is the first since power-on.
	logic lock_fail_ff; // Lock was low at the check point.
	logic refused_ff; // A channel write was refused.
	logic [23:0] elapsed_ff; // Cycles in the present state.
	logic [14:0] pre_cnt_ff; // Preamble half-bit divider.
	logic pre_bit_ff; // Present preamble level.
	logic lock_ok; // Qualified lock level.
	logic [31:0] rd_mux; // Read value before its register.
	shift_if sq (); // Word hand-over to the shifter.

	// Reset asserts at once and releases through two flip-flops.
	always_ff @(posedge sys_clk or negedge rstn) begin
		if (!rstn) begin
			rst_meta_ff <= 1'b0;
			rst_n <= 1'b0;
		end else begin
			rst_meta_ff <= 1'b1;
			rst_n <= rst_meta_ff;
		end
	end

	// Reference word: operation bits at its head, then a spare zero.
	wire [15:0] division = synth_pkg::BASE_DIVISION + {9'h000, chan_ff}; // (R16)
	wire [10:0] prog_cnt = {1'b0, division[15:synth_pkg::PRESCALE_SHIFT]}; // (R19)
	wire [6:0] swallow_cnt = {1'b0, division[5:0]}; // (R20)
	wire [18:0] ref_word = {synth_pkg::CHARGE_PUMP_BIT, synth_pkg::LOCK_SEL_BIT, // (R21)
		synth_pkg::PHASE_POL_BIT, 1'b0, synth_pkg::REF_DIVIDER, // (R5) (R17)
		synth_pkg::SELECT_REF};
	wire [18:0] div_word = {prog_cnt, swallow_cnt, synth_pkg::SELECT_DIV}; // (R18)
	assign sq.word = (state_ff == synth_pkg::SQ_SEND_DIV) ? div_word : ref_word;
	assign sq.start = (state_ff == synth_pkg::SQ_SEND_REF) ||
		(state_ff == synth_pkg::SQ_SEND_DIV);

	// Register decode.
	wire wr_ctrl = wr && (addr == synth_pkg::CTRL_OFS);
	wire wr_chan = wr && (addr == synth_pkg::CHAN_OFS);
	wire wr_stat = wr && (addr == synth_pkg::STATUS_OFS);
	wire chan_ok = (wdata[6:0] < synth_pkg::NUM_CHANNELS) && (wdata[31:7] == 25'h0);
	wire tx_side = (state_ff == synth_pkg::SQ_TX_WAIT) ||
		(state_ff == synth_pkg::SQ_PREAMBLE) || (state_ff == synth_pkg::SQ_TX);
	wire powered = (state_ff != synth_pkg::SQ_OFF);
	wire chan_take = wr_chan && chan_ok && !tx_side && powered; // (R9)
	wire chan_refuse = wr_chan && !chan_take;
	wire settled = (state_ff == synth_pkg::SQ_RX) || (state_ff == synth_pkg::SQ_TX);
	wire busy = !settled && powered && (state_ff != synth_pkg::SQ_UNPROG);
	wire power_req = ctrl_ff[synth_pkg::CTRL_POWER];
	wire tx_req = ctrl_ff[synth_pkg::CTRL_TX];
	wire cold = ctrl_ff[synth_pkg::CTRL_COLD];

	// Wait targets, as last-cycle counts of the state timer.
	wire [23:0] settle_end = first_ff ? 24'(FIRST_SETTLE_CYC - 1) : // (R7)
		24'(RESETTLE_CYC - 1); // (R8)
	wire [23:0] rx_end = cold ? 24'(SWITCH_CYC + COLD_EXTRA_CYC - 1) : // (R15)
		24'(SWITCH_CYC - 1); // (R10)
	wire at_check = (state_ff == synth_pkg::SQ_SETTLE) &&
		(elapsed_ff == 24'(LOCK_CHECK_CYC - 1));
	wire lock_miss = at_check && !lock_ok; // (R12)

	// Sequencer next state.
	always_comb begin
		nxt_state = state_ff;
		case (state_ff)
			synth_pkg::SQ_OFF: begin
				// Selects were already inactive; only now is power applied.
				if (power_req) begin
					nxt_state = synth_pkg::SQ_UNPROG; // (R6)
				end
			end
			synth_pkg::SQ_UNPROG: begin
				if (!power_req) begin
					nxt_state = synth_pkg::SQ_OFF;
				end else if (pend_ff) begin
					nxt_state = synth_pkg::SQ_SEND_REF;
				end
			end
			synth_pkg::SQ_SEND_REF: begin
				if (!sq.busy) begin
					nxt_state = synth_pkg::SQ_WAIT_REF; // (R4)
				end
			end
			synth_pkg::SQ_WAIT_REF: begin
				if (sq.done) begin
					nxt_state = synth_pkg::SQ_SEND_DIV;
				end
			end
			synth_pkg::SQ_SEND_DIV: begin
				if (!sq.busy) begin
					nxt_state = synth_pkg::SQ_WAIT_DIV;
				end
			end
			synth_pkg::SQ_WAIT_DIV: begin
				if (sq.done) begin
					nxt_state = synth_pkg::SQ_SETTLE;
				end
			end
			synth_pkg::SQ_SETTLE: begin
				if (elapsed_ff == settle_end) begin
					nxt_state = synth_pkg::SQ_RX;
				end
			end
			synth_pkg::SQ_RX: begin
				// A waiting channel change beats a switch to transmit.
				if (!power_req) begin
					nxt_state = synth_pkg::SQ_OFF;
				end else if (pend_ff) begin
					nxt_state = synth_pkg::SQ_SEND_REF; // (R9)
				end else if (tx_req) begin
					nxt_state = synth_pkg::SQ_TX_WAIT;
				end
			end
			synth_pkg::SQ_TX_WAIT: begin
				if (elapsed_ff == 24'(SWITCH_CYC - 1)) begin
					nxt_state = synth_pkg::SQ_PREAMBLE; // (R11)
				end
			end
			synth_pkg::SQ_PREAMBLE: begin
				if (elapsed_ff == 24'(PREAMBLE_CYC - 1)) begin
					nxt_state = synth_pkg::SQ_TX; // (R14)
				end
			end
			synth_pkg::SQ_TX: begin
				if (!tx_req || !power_req) begin
					nxt_state = synth_pkg::SQ_RX_WAIT;
				end
			end
			synth_pkg::SQ_RX_WAIT: begin
				if (elapsed_ff == rx_end) begin
					nxt_state = synth_pkg::SQ_RX; // (R10)
				end
			end
			default: begin
				nxt_state = synth_pkg::SQ_OFF;
			end
		endcase
	end

	// Sequencer state and per-state timer.
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			state_ff <= synth_pkg::SQ_OFF;
			elapsed_ff <= 24'h000000;
		end else begin
			state_ff <= nxt_state;
			elapsed_ff <= (nxt_state != state_ff) ? 24'h000000 : elapsed_ff + 24'h000001;
		end
	end

	// Mode pins follow the next state, so they change with it.
	wire nxt_tx = (nxt_state == synth_pkg::SQ_TX_WAIT) ||
		(nxt_state == synth_pkg::SQ_PREAMBLE) || (nxt_state == synth_pkg::SQ_TX);
	wire nxt_on = (nxt_state != synth_pkg::SQ_OFF);
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			tx_select_n <= 1'b1; // (R6)
			rx_select_n <= 1'b1;
			power_en <= 1'b0;
		end else begin
			tx_select_n <= !(nxt_on && nxt_tx); // (R23)
			rx_select_n <= !(nxt_on && !nxt_tx);
			power_en <= nxt_on;
		end
	end

	// Control and channel registers; a channel write queues a change.
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			ctrl_ff <= synth_pkg::CTRL_RESET;
			chan_ff <= synth_pkg::CHAN_RESET;
			pend_ff <= 1'b0;
		end else begin
			ctrl_ff <= wr_ctrl ? wdata[2:0] : ctrl_ff;
			chan_ff <= chan_take ? wdata[6:0] : chan_ff;
			// A write in the cycle the old one is taken stays pending.
			pend_ff <= chan_take || (pend_ff && state_ff != synth_pkg::SQ_SEND_REF &&
				powered);
		end
	end

	// Sticky flags, cleared by writing one, and the first-settle marker; a new event wins over the clear.
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			lock_fail_ff <= 1'b0;
			refused_ff <= 1'b0;
			first_ff <= 1'b1;
		end else begin
			lock_fail_ff <= lock_miss || (lock_fail_ff && !(wr_stat && wdata[4]));
			refused_ff <= chan_refuse || (refused_ff && !(wr_stat && wdata[5]));
			first_ff <= !powered || (first_ff && nxt_state != synth_pkg::SQ_RX);
		end
	end

	// Preamble toggles each half bit; payload passes only once in transmit.
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			pre_cnt_ff <= 15'h0000;
			pre_bit_ff <= 1'b1;
			transmit_data_in <= 1'b0;
		end else begin
			if (state_ff != synth_pkg::SQ_PREAMBLE) begin
				pre_cnt_ff <= 15'h0000;
				pre_bit_ff <= 1'b1;
			end else if (pre_cnt_ff == 15'(PREAMBLE_HALF_CYC - 1)) begin
				pre_cnt_ff <= 15'h0000;
				pre_bit_ff <= !pre_bit_ff; // (R14)
			end else begin
				pre_cnt_ff <= pre_cnt_ff + 15'h0001;
			end
			transmit_data_in <= nxt_tx && (state_ff == synth_pkg::SQ_PREAMBLE ? pre_bit_ff :
				state_ff == synth_pkg::SQ_TX && tx_bit);
		end
	end

	// Read data stand for one cycle after the strobe, zero otherwise.
	wire [7:0] status = {state_ff == synth_pkg::SQ_PREAMBLE, tx_side, refused_ff,
		lock_fail_ff, busy, lock_ok, settled, powered};
	always_comb begin
		rd_mux = 32'h00000000;
		case (addr)
			synth_pkg::CTRL_OFS: rd_mux = {29'h0, ctrl_ff};
			synth_pkg::CHAN_OFS: rd_mux = {25'h0, chan_ff};
			synth_pkg::STATUS_OFS: rd_mux = {24'h0, status};
			default: rd_mux = 32'h00000000;
		endcase
	end
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			rdata <= 32'h00000000;
		end else begin
			rdata <= rd ? rd_mux : 32'h00000000;
		end
	end

	// Serial port to the synthesizer.
	serial_shifter u_shift (
		.sys_clk(sys_clk),
		.rst_n(rst_n),
		.sq(sq.shifter),
		.pll_sclk(pll_sclk),
		.pll_sdata(pll_sdata),
		.latch_strobe(latch_strobe)
	);

	// Lock indicator conditioning.
	lock_qualifier u_lock (
		.sys_clk(sys_clk),
		.rst_n(rst_n),
		.lock_raw(lock_indicator),
		.lock_ok(lock_ok)
	);
endmodule : synth_host_ctrl

// file: tb/synth_host_ctrl_assertions.sv
// Purpose: Port checks of the synthesizer host.
// Assumes: Outputs are registered on sys_clk.
// Notes: A helper rebuilds each serial word as the device takes it.
`timescale 1ns/100ps
module synth_host_ctrl_assertions (
	input wire logic sys_clk,
	input wire logic rstn,
	input wire logic pll_sclk,
	input wire logic pll_sdata,
	input wire logic latch_strobe,
	input wire logic tx_select_n,
	input wire logic rx_select_n,
	input wire logic power_en,
	input wire logic transmit_data_in
);
	logic sclk_q_ff; // Serial clock one cycle ago.
	logic [18:0] sr_ff; // Word shifted so far.
	logic [4:0] bits_ff; // Serial clock rises since the last latch pulse.
	logic sclk_rise; // The device takes a bit here.
	assign sclk_rise = pll_sclk & ~sclk_q_ff;
	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (!rstn);
	// The count clears during the latch pulse, so words start from zero.
	always_ff @(posedge sys_clk or negedge rstn) begin
		if (!rstn) begin
			sclk_q_ff <= 1'h0;
			sr_ff <= 19'h0;
			bits_ff <= 5'h0;
		end else begin
			sclk_q_ff <= pll_sclk;
			if (sclk_rise) begin
				sr_ff <= {sr_ff[17:0], pll_sdata};
				bits_ff <= bits_ff + 5'h1;
			end else if (latch_strobe) begin
				bits_ff <= 5'h0;
			end
		end
	end
	// One cycle of grace lets power fall with the selects.
	property p_quiet_off;
		!power_en && !$past(power_en) |-> tx_select_n && rx_select_n;
	endproperty
	a_quiet_off: assert property (p_quiet_off) else $error("Select active while unpowered.");
	property p_one_sel;
		tx_select_n || rx_select_n;
	endproperty
	a_one_sel: assert property (p_one_sel) else $error("Both selects active.");
	property p_no_prog_tx;
		!tx_select_n |-> !pll_sclk && !latch_strobe;
	endproperty
	a_no_prog_tx: assert property (p_no_prog_tx) else $error("Serial activity in transmit.");
	property p_latch_idle;
		latch_strobe |-> !pll_sclk;
	endproperty
	a_latch_idle: assert property (p_latch_idle) else $error("Latch high while clocking.");
	property p_latch_len;
		$rose(latch_strobe) |-> latch_strobe [*8] ##1 !latch_strobe;
	endproperty
	a_latch_len: assert property (p_latch_len) else $error("Latch pulse length wrong.");
	property p_bit_count;
		$rose(latch_strobe) |-> bits_ff == 5'h13;
	endproperty
	a_bit_count: assert property (p_bit_count) else $error("Word is not 19 bits.");
	property p_ref_word;
		$rose(latch_strobe) && sr_ff[0] |-> sr_ff[18:1] == {4'h2, 14'h06a4};
	endproperty
	a_ref_word: assert property (p_ref_word) else $error("Reference word wrong.");
	property p_div_word;
		$rose(latch_strobe) && !sr_ff[0] |-> sr_ff[18:8] inside {11'h221, 11'h222} && !sr_ff[7];
	endproperty
	a_div_word: assert property (p_div_word) else $error("Divider word out of table.");
	property p_tx_data;
		transmit_data_in |-> !tx_select_n;
	endproperty
	a_tx_data: assert property (p_tx_data) else $error("Data sent outside transmit.");
endmodule : synth_host_ctrl_assertions
bind synth_host_ctrl synth_host_ctrl_assertions synth_host_ctrl_assertions_inst (
	.sys_clk(sys_clk),
	.rstn(rstn),
	.pll_sclk(pll_sclk),
	.pll_sdata(pll_sdata),
	.latch_strobe(latch_strobe),
	.tx_select_n(tx_select_n),
	.rx_select_n(rx_select_n),
	.power_en(power_en),
	.transmit_data_in(transmit_data_in)
);

// file: tb/radio_dev_model.sv
// Purpose: Behavioural radio module: shift register, latches, lock.
// Assumes: hold_unlock keeps the loop from locking.
// Notes: Lock chatters after every divider load before it settles.
`timescale 1ns/100ps
module radio_dev_model (
	input wire logic pll_sclk,
	input wire logic pll_sdata,
	input wire logic latch_strobe,
	input wire logic power_en,
	input wire logic hold_unlock,
	output logic lock_indicator
);
	logic [18:0] sr_ff = 19'h0; // Shift register.
	logic [18:0] ref_latch_ff = 19'h0; // Reference latch.
	logic [18:0] div_latch_ff = 19'h0; // Divider latch.
	int word_count = 0; // Words latched so far.
	initial lock_indicator = 1'h0;
	always @(posedge pll_sclk) sr_ff <= {sr_ff[17:0], pll_sdata};
	// The last bit picks the latch; any word order works.
	always @(posedge latch_strobe) begin
		if (sr_ff[0]) ref_latch_ff <= sr_ff;
		else div_latch_ff <= sr_ff;
		word_count <= word_count + 1;
	end
	// Chatter for about 2 us, then lock unless held off.
	always @(posedge latch_strobe) begin
		if (!sr_ff[0]) begin
			lock_indicator = 1'h0;
			repeat (6) #300 lock_indicator = ~lock_indicator;
			#400 lock_indicator = ~hold_unlock & power_en;
		end
	end
	always @(negedge power_en) lock_indicator = 1'h0;
endmodule : radio_dev_model

// file: tb/synth_host_ctrl_tb.sv
// Purpose: Self-checking bench of the synthesizer host.
// Assumes: Shortened waits; settles exceed the 2500-cycle lock qualify.
// Notes: Software port driven by tasks; the device model answers the pins.
`timescale 1ns/100ps
module synth_host_ctrl_tb;
	localparam int FS = 4000; // First settle.
	localparam int RS = 3500; // Later settle.
	localparam int SW = 50; // Mode switch wait.
	localparam int PR = 100; // Preamble length.
	localparam int CO = 60; // Cold extra wait.
	logic sys_clk, rstn, wr, rd, tx_bit, hold_unlock, pll_sclk, pll_sdata, latch_strobe;
	logic lock_indicator, tx_select_n, rx_select_n, power_en, transmit_data_in;
	logic [3:0] addr;
	logic [31:0] wdata, rdata, st;
	logic [15:0] ratio; // Expected division ratio.
	logic [6:0] chans [3] = '{7'h27, 7'h28, 7'h31}; // Swallow wrap and top.
	int bad_count, num_checks, cyc, t0, t1, n, wc;
	synth_host_ctrl #(.FIRST_SETTLE_CYC(FS), .RESETTLE_CYC(RS), .LOCK_CHECK_CYC(3200),
		.SWITCH_CYC(SW), .PREAMBLE_CYC(PR), .COLD_EXTRA_CYC(CO), .PREAMBLE_HALF_CYC(8))
		synth_host_ctrl_inst (.sys_clk(sys_clk), .rstn(rstn), .addr(addr), .wdata(wdata),
		.wr(wr), .rd(rd), .rdata(rdata), .tx_bit(tx_bit), .pll_sclk(pll_sclk),
		.pll_sdata(pll_sdata), .latch_strobe(latch_strobe), .lock_indicator(lock_indicator),
		.tx_select_n(tx_select_n), .rx_select_n(rx_select_n), .power_en(power_en),
		.transmit_data_in(transmit_data_in));
	radio_dev_model radio_dev_model_inst (.pll_sclk(pll_sclk), .pll_sdata(pll_sdata),
		.latch_strobe(latch_strobe), .power_en(power_en), .hold_unlock(hold_unlock),
		.lock_indicator(lock_indicator));
	initial begin
		sys_clk = 1'h0;
		forever #4 sys_clk = ~sys_clk;
	end
	always @(posedge sys_clk) cyc <= cyc + 1;
	task automatic test_done;
		if (bad_count == 0 && num_checks > 0) begin
			$display("Regression OK");
		end else begin
			$display("Regression broken");
		end
		$finish;
	endtask : test_done
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		num_checks++;
		if (seen !== exp) begin
			bad_count++;
			$display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask : chk
	task automatic wr_reg(input logic [3:0] a, input logic [31:0] d);
		@(posedge sys_clk);
		addr <= a;
		wdata <= d;
		wr <= 1'h1;
		@(posedge sys_clk);
		wr <= 1'h0;
	endtask : wr_reg
	// Read data stand only in the cycle after the strobe.
	task automatic rd_reg(input logic [3:0] a, output logic [31:0] d);
		@(posedge sys_clk);
		addr <= a;
		rd <= 1'h1;
		@(posedge sys_clk);
		rd <= 1'h0;
		#1 d = rdata;
	endtask : rd_reg
	task automatic wait_bit(input int b, input logic v);
		n = 0;
		do begin
			rd_reg(synth_pkg::STATUS_OFS, st);
			n++;
		end while (st[b] !== v && n < 6000);
		if (n >= 6000) bad_count++;
	endtask : wait_bit
	// Program a channel, time the settle, check the latches.
	task automatic prog(input logic [6:0] c, input int s, input logic [31:0] e);
		wr_reg(synth_pkg::CHAN_OFS, {25'h0, c});
		t0 = cyc;
		wait_bit(synth_pkg::ST_READY, 1'h0);
		wait_bit(synth_pkg::ST_READY, 1'h1);
		chk(st, e);
		chk(32'(cyc - t0 >= s + 600 && cyc - t0 <= s + 800), 32'h1);
		ratio = 16'h8858 + {9'h0, c};
		chk({13'h0, radio_dev_model_inst.div_latch_ff},
			{14'h0, ratio[15:6], 1'h0, ratio[5:0], 1'h0});
		chk({13'h0, radio_dev_model_inst.ref_latch_ff}, {13'h0, 4'h2, 14'h06a4, 1'h1});
	endtask : prog
	initial begin
		repeat (60000) @(posedge sys_clk);
		bad_count++;
		test_done();
	end
	initial begin
		{rstn, wr, rd, tx_bit, hold_unlock, cyc, bad_count, num_checks} = '0;
		addr = 4'h0;
		wdata = 32'h0;
		repeat (6) @(posedge sys_clk);
		rstn <= 1'h1;
		repeat (3) @(posedge sys_clk);
		#1 chk({29'h0, power_en, tx_select_n, rx_select_n}, 32'h3);
		rd_reg(4'hc, st);
		chk(st, 32'h0);
		wr_reg(synth_pkg::CHAN_OFS, 32'h3);
		rd_reg(synth_pkg::STATUS_OFS, st);
		chk(st, 32'h20);
		wr_reg(synth_pkg::STATUS_OFS, 32'h20);
		wr_reg(synth_pkg::CTRL_OFS, 32'h1);
		rd_reg(synth_pkg::CTRL_OFS, st);
		chk(st, 32'h1);
		prog(7'h0, FS, 32'h7);
		foreach (chans[i]) prog(chans[i], RS, 32'h7);
		wr_reg(synth_pkg::CHAN_OFS, 32'h32);
		rd_reg(synth_pkg::STATUS_OFS, st);
		chk(st, 32'h27);
		wr_reg(synth_pkg::STATUS_OFS, 32'h20);
		// Transmit: switch wait, then preamble.
		wr_reg(synth_pkg::CTRL_OFS, 32'h3);
		t0 = cyc;
		while (transmit_data_in !== 1'h1 && cyc - t0 < 1000) begin
			@(posedge sys_clk);
			#1;
		end
		t1 = cyc;
		chk(32'(t1 - t0 >= SW && t1 - t0 <= SW + 8), 32'h1);
		chk({30'h0, tx_select_n, rx_select_n}, 32'h1);
		repeat (4) @(posedge sys_clk);
		#1 chk(32'(transmit_data_in), 32'h1);
		repeat (8) @(posedge sys_clk);
		#1 chk(32'(transmit_data_in), 32'h0);
		rd_reg(synth_pkg::STATUS_OFS, st);
		chk(st, 32'hcd);
		wc = radio_dev_model_inst.word_count;
		wr_reg(synth_pkg::CHAN_OFS, 32'h5);
		wait_bit(synth_pkg::ST_READY, 1'h1);
		chk(32'(cyc - t1 >= PR - 4 && cyc - t1 <= PR + 12), 32'h1);
		chk(st, 32'h67);
		chk(radio_dev_model_inst.word_count, wc);
		@(posedge sys_clk);
		tx_bit <= 1'h1;
		repeat (3) @(posedge sys_clk);
		#1 chk(32'(transmit_data_in), 32'h1);
		wr_reg(synth_pkg::STATUS_OFS, 32'h20);
		// Cold return to receive.
		wr_reg(synth_pkg::CTRL_OFS, 32'h5);
		t0 = cyc;
		wait_bit(synth_pkg::ST_READY, 1'h0);
		wait_bit(synth_pkg::ST_READY, 1'h1);
		chk(32'(cyc - t0 >= SW + CO && cyc - t0 <= SW + CO + 12), 32'h1);
		chk({29'h0, transmit_data_in, tx_select_n, rx_select_n}, 32'h2);
		chk(st, 32'h7);
		hold_unlock = 1'h1;
		prog(7'h2, RS, 32'h13);
		wr_reg(synth_pkg::STATUS_OFS, 32'h10);
		rd_reg(synth_pkg::STATUS_OFS, st);
		chk(st, 32'h3);
		wr_reg(synth_pkg::CTRL_OFS, 32'h0);
		repeat (3) @(posedge sys_clk);
		#1 chk({29'h0, power_en, tx_select_n, rx_select_n}, 32'h3);
		test_done();
	end
endmodule : synth_host_ctrl_tb
